// *** adcc_pkg.sv ***
// Purpose: Shared constants and types for the converter control block
// Assumes: 32-bit classic Wishbone, word-per-register, byte address = 4 * index
// Notes: Registers are eight bits wide in the low lane; upper bits read zero
//
// How it works
// - Low byte: result bits 1..0 at 7..6
// - Mode bit: 0 single, 1 scan
// - Start bit 0 halts all conversion
// - Single: one conversion, then start self-clears
// - Scan: cycle channels until start written 0
// - Enable 0 blocks end interrupt request
// - High byte holds result bits 9..2
// - End flag sets on single/scan completion
// - End flag clears: reset, standby, read-write0, transfer
// - Software writes only 0 to end flag
package adcc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_RESULT_HIGH_A = 16'hfee0;
   localparam logic [15:0] IDX_RESULT_LOW_A = 16'hfee1;
   localparam logic [15:0] IDX_RESULT_HIGH_B = 16'hfee2;
   localparam logic [15:0] IDX_RESULT_LOW_B = 16'hfee3;
   localparam logic [15:0] IDX_RESULT_HIGH_C = 16'hfee4;
   localparam logic [15:0] IDX_RESULT_LOW_C = 16'hfee5;
   localparam logic [15:0] IDX_RESULT_HIGH_D = 16'hfee6;
   localparam logic [15:0] IDX_RESULT_LOW_D = 16'hfee7;
   localparam logic [15:0] IDX_CONTROL_STATUS = 16'hfee8;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hfee9;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hfeea;

   // Bus widths
   localparam int ADR_W = 18;
   localparam int DAT_W = 32;
   localparam int RES_W = 10;

   // Control/status field positions
   localparam int F_END_FLAG = 7;
   localparam int F_END_IRQ_EN = 6;
   localparam int F_START = 5;
   localparam int F_SCAN = 4;
   localparam int F_CLK_SEL = 3;
   localparam int F_CH_MSB = 2;

   // Interrupt status bits
   localparam int IRQ_END = 0;
   localparam int IRQ_RESULT = 1;
   localparam int IRQ_W = 2;

   // Reset values
   localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

   // Sequencer states
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} adcc_seq_e;

   // Request to the converter core
   typedef struct packed {
      logic start;
      logic [2:0] channel;
      logic clockSelect;
   } adcc_req_s;

   // Answer from the converter core
   typedef struct packed {
      logic done;
      logic [RES_W-1:0] result;
   } adcc_rsp_s;

endpackage : adcc_pkg

// *** adcc_result_mem.sv ***
// Purpose: Four result words of ten bits, one write port, registered read
// Assumes: Same clock as the controller
// Notes: Read data appear one edge after the address is presented
`timescale 1ns/10ps
`default_nettype none
module adcc_result_mem
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Write port
   input wire logic wrEn,
   input wire logic [1:0] wrAddr,
   input wire logic [adcc_pkg::RES_W-1:0] wrData,
   // Read port
   input wire logic [1:0] rdAddr,
   output logic [adcc_pkg::RES_W-1:0] rdData
);
   import adcc_pkg::*;

   logic [RES_W-1:0] mem_q [4]; // Result words A..D

   // Store results, cleared by reset
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (!nrst)
            mem_q[i] <= '0;
         else if (wrEn && wrAddr == 2'(i))
            mem_q[i] <= wrData;
      end
   end

   // Registered read
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         rdData <= '0;
      else
         rdData <= mem_q[rdAddr];
   end
endmodule : adcc_result_mem
`default_nettype wire

// *** adcc_ctrl.sv ***
// Purpose: Converter control, result and status registers with bus slave
// Assumes: Converter core runs on clk_sys; its answer is one-cycle done pulse
// Notes: Bus answers two edges after the request; writes land at the ack edge
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module adcc_ctrl
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [adcc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [adcc_pkg::DAT_W-1:0] wb_dat_i,
   output logic [adcc_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Converter core
   output adcc_pkg::adcc_req_s convReq,
   input wire adcc_pkg::adcc_rsp_s convRsp,
   // System events
   input wire logic standbyEnter,
   input wire logic transferServe,
   // Interrupts
   output logic conversionEndInterrupt,
   output logic irq
);
   import adcc_pkg::*;

   // Decode a word index to a result slot
   function automatic logic [1:0] slotOf(input logic [15:0] idx);
      slotOf = idx[2:1];
   endfunction : slotOf

   // True for any of the eight result byte indices
   function automatic logic isResult(input logic [15:0] idx);
      isResult = (idx >= IDX_RESULT_HIGH_A) && (idx <= IDX_RESULT_LOW_D);
   endfunction : isResult

   // Bus state
   logic pend_q; // Request seen, read data being fetched
   logic [15:0] idx; // Word index of the request
   logic busWrite; // Write taking effect this edge
   logic busRead; // Read answered this edge
   logic laneLow; // Low byte lane enabled

   // Control/status fields
   logic endFlag_q; // Conversion end flag
   logic endIrqEn_q; // End interrupt enable
   logic start_q; // Conversion start bit
   logic scan_q; // Scan mode select
   logic clkSel_q; // Conversion clock select
   logic [2:0] chSel_q; // Channel select code
   logic flagSeen_q; // End flag read as one since last clear
   logic [7:0] csrValue; // Assembled control/status byte

   // Interrupt status and mask
   logic [IRQ_W-1:0] irqStatus_q; // Sticky event bits
   logic [IRQ_W-1:0] irqMask_q; // Enable mask

   // Sequencer
   adcc_seq_e seq_q; // Sequencer state
   logic [2:0] curCh_q; // Channel being converted
   logic [2:0] baseCh; // First channel of the scan group
   logic [2:0] lastCh; // Last channel of the scan group
   logic resultWr; // Accepted result this cycle
   logic passEnd; // Completion that sets the end flag
   logic hwStartClr; // Hardware clears start bit

   // Result memory port
   logic [RES_W-1:0] memRd; // Registered read of the addressed slot

   // Current request decode
   assign idx = wb_adr_i[ADR_W-1:2];
   assign laneLow = wb_sel_i[0];
   assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && pend_q && !wb_ack_o;
   assign busRead = wb_cyc_i && wb_stb_i && !wb_we_i && pend_q && !wb_ack_o;

   // Scan group bounds
   assign baseCh = {chSel_q[F_CH_MSB], 2'b00};
   assign lastCh = chSel_q;

   // A result lands only while the sequencer waits and start is still set
   assign resultWr = (seq_q == SEQ_WAIT) && convRsp.done && start_q;

   // Single completes each time, scan at the end of the group
   assign passEnd = resultWr && (!scan_q || curCh_q == lastCh);

   // Single mode drops start after its one conversion
   assign hwStartClr = resultWr && !scan_q;

   // Byte of control/status as software sees it
   assign csrValue = {endFlag_q, endIrqEn_q, start_q, scan_q, clkSel_q, chSel_q};

   // Result words, read port follows the bus slot
   adcc_result_mem u_mem
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .wrEn(resultWr),
      .wrAddr(curCh_q[1:0]),
      .wrData(convRsp.result),
      .rdAddr(slotOf(idx)),
      .rdData(memRd)
   );

   // Request handshake: one fetch cycle, then ack for one cycle
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         pend_q <= 1'b0;
         wb_ack_o <= 1'b0;
      end
      else if (wb_ack_o)
      begin
         // Drop ack the cycle after giving it
         pend_q <= 1'b0;
         wb_ack_o <= 1'b0;
      end
      else if (wb_cyc_i && wb_stb_i && !pend_q)
         pend_q <= 1'b1;
      else if (pend_q)
         wb_ack_o <= 1'b1;
   end

   // Read data, loaded at the ack edge
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         wb_dat_o <= '0;
      else if (busRead)
      begin
         wb_dat_o <= '0;
         if (isResult(idx))
         begin
            if (idx[0])
               wb_dat_o[7:6] <= memRd[1:0];
            else
               wb_dat_o[7:0] <= memRd[RES_W-1:2];
         end
         else if (idx == IDX_CONTROL_STATUS)
            wb_dat_o[7:0] <= csrValue;
         else if (idx == IDX_IRQ_STATUS)
            wb_dat_o[IRQ_W-1:0] <= irqStatus_q;
         else if (idx == IDX_IRQ_MASK)
            wb_dat_o[IRQ_W-1:0] <= irqMask_q;
      end
      else if (!wb_cyc_i)
         wb_dat_o <= '0;
   end

   // Plain control fields
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         endIrqEn_q <= RST_CONTROL_STATUS[F_END_IRQ_EN];
         scan_q <= RST_CONTROL_STATUS[F_SCAN];
         clkSel_q <= RST_CONTROL_STATUS[F_CLK_SEL];
         chSel_q <= RST_CONTROL_STATUS[2:0];
      end
      else if (busWrite && laneLow && idx == IDX_CONTROL_STATUS)
      begin
         endIrqEn_q <= wb_dat_i[F_END_IRQ_EN];
         scan_q <= wb_dat_i[F_SCAN];
         clkSel_q <= wb_dat_i[F_CLK_SEL];
         chSel_q <= wb_dat_i[2:0];
      end
   end

   // Start bit: software sets or clears, hardware clears after single
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         start_q <= RST_CONTROL_STATUS[F_START];
      else if (busWrite && laneLow && idx == IDX_CONTROL_STATUS)
         start_q <= wb_dat_i[F_START];
      else if (hwStartClr)
         start_q <= 1'b0;
   end

   // Remember that software has seen the end flag set
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         flagSeen_q <= 1'b0;
      else if (!endFlag_q)
         flagSeen_q <= 1'b0;
      else if (busRead && idx == IDX_CONTROL_STATUS)
         flagSeen_q <= 1'b1;
   end

   // End flag: set wins over standby, transfer and software clears; reset wins over set
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         endFlag_q <= RST_CONTROL_STATUS[F_END_FLAG];
      else if (passEnd)
         endFlag_q <= 1'b1;
      else if (standbyEnter || transferServe)
         endFlag_q <= 1'b0;
      else if (busWrite && laneLow && idx == IDX_CONTROL_STATUS)
      begin
         // Only a zero after a read of one clears; a one changes nothing
         if (!wb_dat_i[F_END_FLAG] && flagSeen_q)
            endFlag_q <= 1'b0;
      end
   end

   // Sequencer: issue a conversion, wait for the core, step the channel
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         seq_q <= SEQ_IDLE;
         curCh_q <= '0;
      end
      else if (!start_q)
         seq_q <= SEQ_IDLE;
      else
      begin
         unique case (seq_q)
            SEQ_IDLE:
            begin
               // Single takes the code, scan starts at the group base
               curCh_q <= scan_q ? baseCh : chSel_q;
               seq_q <= SEQ_ISSUE;
            end
            SEQ_ISSUE:
               seq_q <= SEQ_WAIT;
            SEQ_WAIT:
            begin
               if (convRsp.done)
               begin
                  if (!scan_q)
                     seq_q <= SEQ_IDLE;
                  else
                  begin
                     // Wrap around the group for the next pass
                     curCh_q <= (curCh_q == lastCh) ? baseCh : curCh_q + 3'h1;
                     seq_q <= SEQ_ISSUE;
                  end
               end
            end
         endcase
      end
   end

   // Request to the core, one-cycle start pulse from a flip-flop
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         convReq <= '0;
      else
      begin
         convReq.start <= start_q && seq_q == SEQ_ISSUE;
         convReq.channel <= curCh_q;
         convReq.clockSelect <= clkSel_q;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         irqMask_q <= RST_IRQ;
      else if (busWrite && laneLow && idx == IDX_IRQ_MASK)
         irqMask_q <= wb_dat_i[IRQ_W-1:0];
   end

   // Sticky events, cleared by a read; a new event wins
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         irqStatus_q <= RST_IRQ;
      else
      begin
         for (int i = 0; i < IRQ_W; i++)
         begin
            if ((i == IRQ_END && passEnd) || (i == IRQ_RESULT && resultWr))
               irqStatus_q[i] <= 1'b1;
            else if (busRead && idx == IDX_IRQ_STATUS)
               irqStatus_q[i] <= 1'b0;
         end
      end
   end

   // Interrupt outputs from flip-flops
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         conversionEndInterrupt <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         conversionEndInterrupt <= endFlag_q && endIrqEn_q;
         irq <= |(irqStatus_q & irqMask_q);
      end
   end
endmodule : adcc_ctrl
`default_nettype wire

// *** adcc_ctrl_asserts.sv ***
// Purpose: Port checks of the converter control block
// Assumes: Bus answers two edges after the request
// Notes: Shadows of control and mask bytes follow bus writes
`timescale 1ns/10ps
`default_nettype none
module adcc_ctrl_asserts
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [adcc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [adcc_pkg::DAT_W-1:0] wb_dat_i,
   input wire logic [adcc_pkg::DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Core, events, interrupts
   input wire adcc_pkg::adcc_req_s convReq,
   input wire adcc_pkg::adcc_rsp_s convRsp,
   input wire logic standbyEnter,
   input wire logic transferServe,
   input wire logic conversionEndInterrupt,
   input wire logic irq
);
   import adcc_pkg::*;
   logic wrHit; // Write taken at ack
   logic lowRd; // Read of a low result byte
   logic [7:0] ctl_q; // Last control byte written
   logic [1:0] msk_q; // Last mask written
   assign wrHit = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
   assign lowRd = (wb_adr_i[17:5] == 13'h1fdc) & wb_adr_i[2] & !wb_we_i;
   // Shadows land one edge after the design's own update
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         ctl_q <= 8'h00;
         msk_q <= 2'h0;
      end
      else if (wrHit && wb_adr_i[17:2] == IDX_CONTROL_STATUS)
         ctl_q <= wb_dat_i[7:0];
      else if (wrHit && wb_adr_i[17:2] == IDX_IRQ_MASK)
         msk_q <= wb_dat_i[1:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_latency: assert property ($rose(wb_stb_i) |-> !wb_ack_o[*2] ##1 wb_ack_o)
      else $error("ack latency wrong");
   a_write_quiet: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
      else $error("data on write ack");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read bits set");
   a_low_tail: assert property (wb_ack_o && lowRd |-> wb_dat_o[5:0] == 6'h0)
      else $error("low byte tail set");
   a_start_gap: assert property (convReq.start |=> !convReq.start[*2])
      else $error("start pulses too close");
   a_end_gate: assert property (!ctl_q[6] |-> !conversionEndInterrupt)
      else $error("end interrupt while disabled");
   a_end_raise: assert property (convRsp.done && ctl_q[6] && ctl_q[5] && !ctl_q[4]
      |-> ##[1:2] conversionEndInterrupt)
      else $error("end interrupt missing");
   a_irq_mask: assert property (msk_q == 2'h0 |-> !irq)
      else $error("irq while masked");
endmodule : adcc_ctrl_asserts
bind adcc_ctrl adcc_ctrl_asserts adcc_ctrl_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .convReq(convReq), .convRsp(convRsp), .standbyEnter(standbyEnter),
   .transferServe(transferServe), .conversionEndInterrupt(conversionEndInterrupt),
   .irq(irq));
`default_nettype wire

// *** adcc_conv_model.sv ***
// Purpose: Behavioural converter core facing the control block
// Assumes: One done pulse per start, after a set latency
// Notes: Result lines change every cycle outside done
`timescale 1ns/10ps
`default_nettype none
module adcc_conv_model
(
   // Clock
   input wire logic clk_sys,
   // Request and answer
   input wire adcc_pkg::adcc_req_s convReq,
   output var adcc_pkg::adcc_rsp_s convRsp,
   // Bench controls
   input wire logic [9:0] value,
   input wire logic [3:0] lat
);
   import adcc_pkg::*;
   logic busy_q = 1'b0; // Conversion in flight
   logic [3:0] cnt_q = 4'h0; // Cycles left
   logic [9:0] held_q = 10'h0; // Captured result
   initial convRsp = '0;
   // One answer per start, a restart drops the old one
   always @(posedge clk_sys)
   begin
      convRsp.done <= 1'b0;
      convRsp.result <= ~convRsp.result;
      if (convReq.start)
      begin
         busy_q <= 1'b1;
         cnt_q <= lat;
         held_q <= value;
      end
      else if (busy_q && cnt_q <= 4'h1)
      begin
         busy_q <= 1'b0;
         convRsp.done <= 1'b1;
         convRsp.result <= held_q;
      end
      else if (busy_q)
         cnt_q <= cnt_q - 4'h1;
   end
endmodule : adcc_conv_model
`default_nettype wire

// *** adcc_tb.sv ***
// Purpose: Self-checking bench of the converter control block
// Assumes: Wishbone answer comes within twenty edges
// Notes: Expected channels sit in a queue, results in the bench
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import adcc_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [17:0] wb_adr_i = 18'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic standbyEnter = 1'b0;
   logic transferServe = 1'b0;
   logic conversionEndInterrupt;
   logic irq;
   adcc_req_s convReq;
   adcc_rsp_s convRsp;
   logic [9:0] value = 10'h0; // Next result of the core
   logic [3:0] lat = 4'h1; // Core latency
   logic scanOn = 1'b0; // Scan channel check active
   logic [31:0] seed = 32'h6521;
   int scanIdx = 0;
   int expCh[$]; // Conversions still expected
   int errors = 0;
   int checks_done = 0;
   always #25 clk_sys = ~clk_sys;
   adcc_ctrl adcc_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .convReq(convReq),
      .convRsp(convRsp), .standbyEnter(standbyEnter), .transferServe(transferServe),
      .conversionEndInterrupt(conversionEndInterrupt), .irq(irq));
   adcc_conv_model adcc_conv_model_inst (.clk_sys(clk_sys), .convReq(convReq),
      .convRsp(convRsp), .value(value), .lat(lat));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One classic cycle, held until ack, then one idle cycle
   task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= {i, 2'b00};
      wb_dat_i <= {24'h0, d};
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      chk("bus ack", 32'h1, {31'h0, wb_ack_o});
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   task automatic rd(input logic [15:0] i, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, i, 8'h00, q);
      chk($sformatf("reg %h", i), e, q);
   endtask : rd
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask : wr
   task automatic close_out;
      if (errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // Every start must match the model of the sequencer
   always @(posedge clk_sys)
   begin
      if (nrst && convReq.start === 1'b1)
      begin
         if (scanOn)
            chk("scan channel", 32'(4 + scanIdx++ % 3), {29'h0, convReq.channel});
         else if (expCh.size() == 0)
            chk("stray start", 32'h0, 32'h1);
         else
            chk("channel", 32'(expCh.pop_front()), {29'h0, convReq.channel});
      end
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      close_out();
   end
   initial
   begin
      logic [31:0] q;
      logic [7:0] ctl;
      logic [2:0] ch;
      int n;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      for (int i = 0; i < 12; i++)
         rd(16'hfee0 + 16'(i), 32'h0);
      rd(16'hfef0, 32'h0);
      wr(IDX_RESULT_LOW_A, 8'hff);
      rd(IDX_RESULT_LOW_A, 32'h0);
      wr(IDX_CONTROL_STATUS, 8'h80);
      rd(IDX_CONTROL_STATUS, 32'h0);
      wr(IDX_IRQ_MASK, 8'h01);
      // Single conversions on every channel, enable and latency varied
      for (int c = 0; c < 8; c++)
      begin
         ch = 3'(c);
         seed = lfsr(seed);
         value <= seed[9:0];
         lat <= 4'(1 + c);
         expCh.push_back(c);
         ctl = {1'b0, ch[0], 2'b10, ch[1], ch};
         wr(IDX_CONTROL_STATUS, ctl);
         n = 0;
         do
         begin
            bus(1'b0, IDX_CONTROL_STATUS, 8'h00, q);
            n++;
         end
         while (q[5] !== 1'b0 && n < 40);
         chk("control", {24'h0, 2'b11 & {1'b1, ctl[6]}, 1'b0, ctl[4:0]}, q);
         chk("end irq", {31'h0, ch[0]}, {31'h0, conversionEndInterrupt});
         chk("clock select", {31'h0, ch[1]}, {31'h0, convReq.clockSelect});
         chk("irq", 32'h1, {31'h0, irq});
         rd(IDX_IRQ_STATUS, 32'h3);
         chk("irq", 32'h0, {31'h0, irq});
         rd(16'hfee0 + {13'h0, ch[1:0], 1'b0}, {24'h0, value[9:2]});
         rd(16'hfee1 + {13'h0, ch[1:0], 1'b0}, {24'h0, value[1:0], 6'h0});
         case (c % 3)
            0: wr(IDX_CONTROL_STATUS, {1'b0, ctl[6], 6'h0});
            1: transferServe <= 1'b1;
            default: standbyEnter <= 1'b1;
         endcase
         @(posedge clk_sys);
         transferServe <= 1'b0;
         standbyEnter <= 1'b0;
         bus(1'b0, IDX_CONTROL_STATUS, 8'h00, q);
         chk("end flag", 32'h0, {31'h0, q[7]});
      end
      // Scan over inputs four to six, then stop
      wr(IDX_IRQ_MASK, 8'h00);
      seed = lfsr(seed);
      value <= seed[9:0];
      lat <= 4'h2;
      scanOn <= 1'b1;
      wr(IDX_CONTROL_STATUS, 8'h36);
      n = 0;
      while (scanIdx < 7 && n < 300)
      begin
         @(posedge clk_sys);
         n++;
      end
      wr(IDX_CONTROL_STATUS, 8'h16);
      repeat (3) @(posedge clk_sys);
      scanOn <= 1'b0;
      chk("scan count", 32'h1, {31'h0, scanIdx >= 7});
      rd(IDX_CONTROL_STATUS, 32'h96);
      chk("irq", 32'h0, {31'h0, irq});
      rd(IDX_IRQ_STATUS, 32'h3);
      rd(IDX_RESULT_HIGH_C, {24'h0, value[9:2]});
      repeat (40) @(posedge clk_sys);
      close_out();
   end
endmodule : testbench
`default_nettype wire
